// [dpb_regs.svh]
/*
  Register offsets, field positions, encodings and reset values of the
  dual-port block RAM. Assumes inclusion by the package and the core.
*/
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH
`define DPB_A_CFG   12'h000
`define DPB_A_STAT  12'h004
`define DPB_A_SLEN  12'h008
`define DPB_F_MODE  2:0
`define DPB_F_CLK   5:4
`define DPB_F_WA    10:8
`define DPB_F_WB    14:12
`define DPB_B_ORA   16
`define DPB_B_RDW   18
`define DPB_B_REJ   0
`define DPB_B_COL   1
`define DPB_M_TDP   3'h0
`define DPB_M_SDP   3'h1
`define DPB_M_SP    3'h2
`define DPB_M_SHIFT 3'h3
`define DPB_M_ROM   3'h4
`define DPB_M_FIFO  3'h5
`define DPB_C_IND   2'h0
`define DPB_C_IO    2'h1
`define DPB_C_RW    2'h2
`define DPB_C_SP    2'h3
`define DPB_W1      3'h0
`define DPB_W2      3'h1
`define DPB_W4      3'h2
`define DPB_W8      3'h3
`define DPB_W16     3'h4
`define DPB_W9      3'h5
`define DPB_W18     3'h6
`define DPB_CFG_RST 32'h0000_0000
`define DPB_UNDEF   18'h2_aaaa
`define DPB_WORDS   256
`define DPB_AW      12
`define DPB_DW      18
`define DPB_IW      8
`endif

// [dpb_pkg.sv]
/*
  Types of the dual-port block RAM: user port bundle and core state.
  Assumes dpb_regs.svh on the include path.
*/
`include "dpb_regs.svh"
package dpb_pkg;
  typedef logic [`DPB_DW-1:0] dpb_word_t;

  typedef struct packed {
    logic                ce_in;
    logic                ce_out;
    logic                clr_in;
    logic                clr_out;
    logic                we;
    logic                re;
    logic [`DPB_AW-1:0]  addr;
    dpb_word_t           din;
  } dpb_port_s;

  typedef struct packed {
    logic                pend;
    logic                we;
    logic                re;
    logic [`DPB_AW-1:0]  addr;
    dpb_word_t           din;
    dpb_word_t           stage;
    dpb_word_t           q;
  } dpb_pst_s;

  typedef struct packed {
    logic [31:0]                  cfg;
    logic [`DPB_IW-1:0]           slen;
    logic [`DPB_IW-1:0]           ptr;
    logic                         rej;
    logic                         col;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         perr;
    dpb_pst_s [1:0]               p;
    dpb_word_t [`DPB_WORDS-1:0]   mem;
  } dpb_st_s;
endpackage

// [dpb_core.sv]
/*
  Dual-port 256 x 18 block RAM with APB configuration: true and simple
  dual-port, split single-port, shift-register, ROM and FIFO storage.
  Assumes one clock; each port clock is a one-cycle enable pulse from
  the user logic, and clears are sampled on the clock.
*/
`include "dpb_regs.svh"
module dpb_core
  import dpb_pkg::*;
(
  input  logic        CORE_CLK,
  input  logic        RESET,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [11:0] PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  dpb_port_s   PORT_A,
  input  dpb_port_s   PORT_B,
  output dpb_word_t   Q_A,
  output dpb_word_t   Q_B
);

  dpb_st_s            s;
  dpb_st_s            n;
  dpb_port_s          pin  [2];
  logic [2:0]         wc   [2];
  logic [`DPB_IW-1:0] idx  [2];
  dpb_word_t          old  [2];
  dpb_word_t          wv   [2];
  dpb_word_t          rv   [2];
  logic               dow  [2];
  logic               dor  [2];
  logic               rdr  [2];
  logic               orr  [2];
  logic               oce  [2];
  logic [2:0]         md;
  logic [1:0]         ck;

  function automatic logic [`DPB_IW-1:0] widx(logic [`DPB_AW-1:0] a,
                                              logic [2:0] w);
    case (w)
      `DPB_W1:          widx = a[11:4];
      `DPB_W2:          widx = a[10:3];
      `DPB_W4:          widx = a[9:2];
      `DPB_W8, `DPB_W9: widx = a[8:1];
      default:          widx = a[7:0];
    endcase
  endfunction

  function automatic logic [4:0] foff(logic [`DPB_AW-1:0] a, logic [2:0] w);
    case (w)
      `DPB_W1: foff = {1'b0, a[3:0]};
      `DPB_W2: foff = {1'b0, a[2:0], 1'b0};
      `DPB_W4: foff = {1'b0, a[1:0], 2'h0};
      `DPB_W8: foff = {1'b0, a[0], 3'h0};
      `DPB_W9: foff = a[0] ? 5'h09 : 5'h00;
      default: foff = 5'h00;
    endcase
  endfunction

  function automatic logic [4:0] wbits(logic [2:0] w);
    case (w)
      `DPB_W1:  wbits = 5'h01;
      `DPB_W2:  wbits = 5'h02;
      `DPB_W4:  wbits = 5'h04;
      `DPB_W8:  wbits = 5'h08;
      `DPB_W16: wbits = 5'h10;
      `DPB_W9:  wbits = 5'h09;
      default:  wbits = 5'h12;
    endcase
  endfunction

  function automatic dpb_word_t msk(logic [2:0] w);
    msk = dpb_word_t'((19'h0_0001 << wbits(w)) - 19'h0_0001);
  endfunction

  // Clock scheme must match memory mode; parity widths pair only together
  function automatic logic cfg_ok(logic [31:0] c);
    logic [2:0] m;
    logic [1:0] k;
    logic       kok;
    m = c[`DPB_F_MODE];
    k = c[`DPB_F_CLK];
    case (m)
      `DPB_M_TDP:              kok = (k == `DPB_C_IND) || (k == `DPB_C_IO);
      `DPB_M_SDP, `DPB_M_FIFO: kok = (k == `DPB_C_IO) || (k == `DPB_C_RW);
      default:                 kok = (k == `DPB_C_SP);
    endcase
    cfg_ok = kok && (m <= `DPB_M_FIFO)
      && (c[`DPB_F_WA] <= `DPB_W18) && (c[`DPB_F_WB] <= `DPB_W18)
      && ((c[`DPB_F_WA] >= `DPB_W9) == (c[`DPB_F_WB] >= `DPB_W9));
  endfunction

  function automatic dpb_st_s rst_st();
    dpb_st_s r;
    r = '0;
    r.cfg = `DPB_CFG_RST;
    // Preload is the ROM image; outputs still start at zero
    for (int k = 0; k < `DPB_WORDS; k++) begin
      r.mem[k] = dpb_word_t'(k);
    end
    return r;
  endfunction

  assign md = s.cfg[`DPB_F_MODE];
  assign ck = s.cfg[`DPB_F_CLK];

  for (genvar g = 0; g < 2; g++) begin : g_port
    dpb_word_t  m;
    logic [4:0] of;
    logic       wok;
    logic       rok;
    logic [`DPB_IW-1:0] wi;
    assign pin[g] = (g == 1) ? PORT_B : PORT_A;
    assign wc[g]  = (g == 1) ? s.cfg[`DPB_F_WB] : s.cfg[`DPB_F_WA];
    assign m      = msk(wc[g]);
    assign of     = foff(s.p[g].addr, wc[g]);
    assign wi     = widx(s.p[g].addr, wc[g]);
    // Split single-port: each port owns one half of the array
    assign idx[g] = (md == `DPB_M_SHIFT) ? s.ptr :
                    (md == `DPB_M_SP) ? {1'(g), wi[6:0]} :
                    wi;
    assign old[g] = s.mem[idx[g]];
    // Simple dual-port styles: A is the write side, B the read side
    assign wok    = (md != `DPB_M_ROM) && !((g == 1) && ((md == `DPB_M_SDP) ||
                    (md == `DPB_M_FIFO) || (md == `DPB_M_SHIFT)));
    assign rok    = !((g == 0) && ((md == `DPB_M_SDP) || (md == `DPB_M_FIFO)));
    assign dow[g] = s.p[g].pend && s.p[g].we && wok;
    assign dor[g] = s.p[g].pend && s.p[g].re && rok
                    && !((md == `DPB_M_SP) && s.p[g].we);
    assign wv[g]  = (md == `DPB_M_SHIFT) ?
                    dpb_word_t'((old[g] << wbits(wc[g])) | (s.p[g].din & m)) :
                    (old[g] & ~dpb_word_t'(m << of)) | dpb_word_t'((s.p[g].din & m) << of);
    assign rv[g]  = (md == `DPB_M_SHIFT) ? old[g] :
                    dow[g] ? (s.p[g].din & m) :
                    (dow[1-g] && (idx[1-g] == idx[g]) && !s.cfg[`DPB_B_RDW]) ?
                    `DPB_UNDEF :
                    (old[g] >> of) & m;
    assign rdr[g] = dor[g] || ((md == `DPB_M_SHIFT) && (g == 0) && dow[g]);
    assign orr[g] = s.cfg[`DPB_B_ORA + g] && (md != `DPB_M_FIFO);
    // Independent: one port clock for all; read/write: read clock on B
    assign oce[g] = ((ck == `DPB_C_IND) || ((ck == `DPB_C_RW) && (g == 1))) ?
                    pin[g].ce_in : pin[g].ce_out;
  end

  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.perr = 1'b0;
    // Setup phase decodes; registered answer costs one cycle, no more
    if (PSEL && !PENABLE) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (PADDR)
        `DPB_A_CFG: n.prdata = s.cfg;
        `DPB_A_STAT: begin
          n.prdata[`DPB_B_REJ] = s.rej;
          n.prdata[`DPB_B_COL] = s.col;
        end
        `DPB_A_SLEN: n.prdata = 32'({s.ptr, s.slen});
        default: n.perr = 1'b1;
      endcase
      if (PWRITE && (PADDR == `DPB_A_CFG) && !cfg_ok(PWDATA)) begin
        n.perr = 1'b1;
      end
    end
    if (PSEL && PENABLE && s.pready && PWRITE) begin
      if (s.perr) begin
        if (PADDR == `DPB_A_CFG) begin
          n.rej = 1'b1;
        end
      end else begin
        case (PADDR)
          `DPB_A_CFG: n.cfg = PWDATA;
          `DPB_A_STAT: begin
            if (PWDATA[`DPB_B_REJ]) begin
              n.rej = 1'b0;
            end
            if (PWDATA[`DPB_B_COL]) begin
              n.col = 1'b0;
            end
          end
          `DPB_A_SLEN: begin
            n.slen = PWDATA[`DPB_IW-1:0];
            n.ptr = '0;
          end
          default: n.rej = s.rej;
        endcase
      end
    end
    // Both ports run every cycle; capture, then commit one cycle later
    for (int i = 0; i < 2; i++) begin
      if (pin[i].clr_in) begin
        n.p[i].pend = 1'b0;
        n.p[i].we = 1'b0;
        n.p[i].re = 1'b0;
        n.p[i].addr = '0;
        n.p[i].din = '0;
      end else begin
        n.p[i].pend = pin[i].ce_in;
        if (pin[i].ce_in) begin
          n.p[i].we = pin[i].we;
          n.p[i].re = pin[i].re;
          n.p[i].addr = pin[i].addr;
          n.p[i].din = pin[i].din;
        end
      end
      if (dow[i]) begin
        n.mem[idx[i]] = wv[i];
      end
      if (rdr[i]) begin
        n.p[i].stage = rv[i];
      end
      if (orr[i]) begin
        if (oce[i]) begin
          n.p[i].q = s.p[i].stage;
        end
      end else begin
        n.p[i].q = n.p[i].stage;
      end
      if (pin[i].clr_out) begin
        n.p[i].stage = '0;
        n.p[i].q = '0;
      end
    end
    // No arbitration: a same-word double write is flagged and trashed
    if (dow[0] && dow[1] && (idx[0] == idx[1])) begin
      n.mem[idx[0]] = `DPB_UNDEF;
      n.col = 1'b1;
    end
    if ((md == `DPB_M_SHIFT) && dow[0]) begin
      n.ptr = (s.ptr == s.slen) ? '0 : s.ptr + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s <= rst_st();
    end else begin
      s <= n;
    end
  end

  assign PRDATA  = s.prdata;
  assign PREADY  = s.pready;
  assign PSLVERR = s.perr;
  assign Q_A     = s.p[0].q;
  assign Q_B     = s.p[1].q;

  a_reset_zero: assert property (@(posedge CORE_CLK)
    $past(RESET) |-> (Q_A == '0) && (Q_B == '0))
    else $error("outputs not zero after reset");

  a_write_late: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (PORT_A.ce_in && PORT_A.we && !PORT_A.clr_in && (md == `DPB_M_TDP)
     && !(PORT_B.ce_in && PORT_B.we && !PORT_B.clr_in)
     && !dow[0] && !dow[1]) |=> ##1 (s.mem[$past(idx[0])] == $past(wv[0])))
    else $error("write not committed one cycle after capture");

  a_thru_same: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (dow[0] && dor[0] && !orr[0] && (md == `DPB_M_TDP) && !PORT_A.clr_out)
    |=> (Q_A == ($past(s.p[0].din) & msk($past(wc[0])))))
    else $error("written word did not flow through");

  a_sp_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ((md == `DPB_M_SP) && s.p[0].pend && s.p[0].we && s.p[0].re && !PORT_A.clr_out)
    |=> $stable(s.p[0].stage))
    else $error("single-port read during write");

  a_cfg_refuse: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (PSEL && PENABLE && PREADY && PWRITE && PSLVERR && (PADDR == `DPB_A_CFG))
    |=> $stable(s.cfg) && s.rej)
    else $error("bad configuration accepted");

  a_width_pair: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wc[0] <= `DPB_W18) && ((wc[0] >= `DPB_W9) == (wc[1] >= `DPB_W9)))
    else $error("illegal width pairing");

  a_fifo_comb: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (md == `DPB_M_FIFO) |=> (Q_A == s.p[0].stage) && (Q_B == s.p[1].stage))
    else $error("fifo output registered");

  a_rom_static: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (md == `DPB_M_ROM) |=> $stable(s.mem))
    else $error("rom contents changed");

  a_outreg_lag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (orr[1] && oce[1] && !PORT_B.clr_out) |=> (Q_B == $past(s.p[1].stage)))
    else $error("output register did not lag");

endmodule // dpb_core

// [dpb_user_model.sv]
/*
  Far-side user logic: drives both memory ports with one-cycle clock pulses.
  Assumes the core samples the port bundles on the rising edge of clk.
*/
module dpb_user_model
  import dpb_pkg::*;
(
  input  wire logic clk,
  output dpb_port_s port_a,
  output dpb_port_s port_b
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    port_a = '0;
    port_b = '0;
  end

  function automatic dpb_port_s mk(input logic c, input logic o, input logic w,
                                   input logic r, input logic [11:0] a, input dpb_word_t d);
    mk = '{c, o, 1'b0, 1'b0, w, r, a, d};
  endfunction

  // One pulse per call; same-word writes on both ports only when the caller asks
  // Callers keep shift widths small and never read+write an empty FIFO
  task automatic go(input logic [1:0] ci, input logic [1:0] co, input logic [1:0] we,
                    input logic [1:0] re, input logic [11:0] a, input dpb_word_t da,
                    input dpb_word_t db);
    @(posedge clk);
    port_a <= mk(ci[0], co[0], we[0], re[0], a, da);
    port_b <= mk(ci[1], co[1], we[1], re[1], a, db);
    @(posedge clk);
    // Released lines flip so a stale value cannot pass for a live one
    port_a <= mk(1'b0, 1'b0, 1'b0, 1'b0, ~a, ~da);
    port_b <= mk(1'b0, 1'b0, 1'b0, 1'b0, ~a, ~db);
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // dpb_user_model

// [dual_port_block_ram_test.sv]
/*
  Self-checking bench for the dual-port block RAM: APB set-up, port traffic.
  Assumes dpb_core and dpb_user_model; one 100 MHz clock.
*/
module dual_port_block_ram_test
  import dpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dpb_port_s   port_a, port_b;
  dpb_word_t   q_a, q_b;
  int          mismatches, samples_checked;

  dpb_core i_dut (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PORT_A(port_a), .PORT_B(port_b), .Q_A(q_a), .Q_B(q_b));
  dpb_user_model i_user (.clk(clk), .port_a(port_a), .port_b(port_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  // Wait is bounded so a dead slave ends the run instead of hanging it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wcfg(input logic [31:0] v, input logic e);
    apb(1'b1, 12'h000, v);
    chk({31'h0, er}, {31'h0, e}, "cfg refusal");
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(q_a, 32'h0000_0000, "qa at reset");
    chk(q_b, 32'h0000_0000, "qb at reset");
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001, "unmapped");
    chk(rd, 32'h0000_0000, "unmapped data");
    for (int c = 0; c < 4; c++)
      wcfg(32'h0000_6600 | (32'(c) << 4), c >= 2);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_6610, "cfg kept");
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "rejected flag");
    apb(1'b1, 12'h004, 32'h0000_0003);
    wcfg(32'h0000_4500, 1'b1);
    wcfg(32'h0000_5600, 1'b0);
    // Input/output clocking: output register moves only on the output pulse
    wcfg(32'h0001_6610, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h1, 12'h005, 18'h1_2345, 18'h0_0000);
    chk(q_a, 32'h0000_0000, "io held");
    i_user.go(2'h0, 2'h1, 2'h0, 2'h0, 12'h005, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0001_2345, "io out pulse");
    wcfg(32'h0000_6600, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h1, 12'h0ff, 18'h2_0001, 18'h0_0000);
    chk(q_a, 32'h0002_0001, "flow through");
    i_user.go(2'h2, 2'h0, 2'h0, 2'h2, 12'h0ff, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0002_0001, "top word b");
    wcfg(32'h0001_6600, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h0, 2'h1, 12'h005, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0002_0001, "out reg lag");
    i_user.go(2'h1, 2'h0, 2'h0, 2'h0, 12'h005, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0001_2345, "out reg data");
    wcfg(32'h0004_6600, 1'b0);
    i_user.go(2'h3, 2'h0, 2'h1, 2'h2, 12'h006, 18'h0_1111, 18'h0_0000);
    chk(q_b, 32'h0000_0006, "old data");
    wcfg(32'h0000_6600, 1'b0);
    i_user.go(2'h3, 2'h0, 2'h1, 2'h2, 12'h006, 18'h0_2222, 18'h0_0000);
    chk(q_b, 32'h0002_aaaa, "undefined read");
    i_user.go(2'h2, 2'h0, 2'h0, 2'h2, 12'h006, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0000_2222, "write landed");
    i_user.go(2'h3, 2'h0, 2'h3, 2'h0, 12'h007, 18'h0_0001, 18'h0_0002);
    i_user.go(2'h1, 2'h0, 2'h0, 2'h1, 12'h007, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0002_aaaa, "collision word");
    apb(1'b0, 12'h004, 32'h0000_0000);
    // Refused width pairing earlier left the reject flag standing
    chk(rd, 32'h0000_0003, "collision flag");
    apb(1'b1, 12'h004, 32'h0000_0003);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "flags cleared");
    wcfg(32'h0003_6615, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h003, 18'h0_0abc, 18'h0_0000);
    i_user.go(2'h2, 2'h0, 2'h0, 2'h2, 12'h003, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0000_0abc, "fifo bypass");
    wcfg(32'h0000_6634, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h009, 18'h3_ffff, 18'h0_0000);
    i_user.go(2'h1, 2'h0, 2'h0, 2'h1, 12'h009, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0000_0009, "rom image");
    wcfg(32'h0000_6632, 1'b0);
    i_user.go(2'h2, 2'h0, 2'h0, 2'h2, 12'h000, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0000_0080, "upper half");
    i_user.go(2'h1, 2'h0, 2'h1, 2'h1, 12'h001, 18'h0_0777, 18'h0_0000);
    chk(q_a, 32'h0000_0009, "sp read during write");
    i_user.go(2'h1, 2'h0, 2'h0, 2'h1, 12'h001, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0000_0777, "sp write landed");
    // Read/write clocking: B output register runs on the read clock pulse
    wcfg(32'h0002_6621, 1'b0);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h00a, 18'h0_0bcd, 18'h0_0000);
    i_user.go(2'h2, 2'h0, 2'h0, 2'h2, 12'h00a, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0000_0080, "read clock lag");
    i_user.go(2'h2, 2'h0, 2'h0, 2'h0, 12'h00a, 18'h0_0000, 18'h0_0000);
    chk(q_b, 32'h0000_0bcd, "read side data");
    wcfg(32'h0000_3333, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0000);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h000, 18'h0_005a, 18'h0_0000);
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h000, 18'h0_0011, 18'h0_0000);
    chk(q_a, 32'h0000_005a, "shift one");
    i_user.go(2'h1, 2'h0, 2'h1, 2'h0, 12'h000, 18'h0_0000, 18'h0_0000);
    chk(q_a, 32'h0000_5a11, "shift two");
    print_verdict();
  end
endmodule // dual_port_block_ram_test
